// File: src/tile_bin_consts.svh
`ifndef TILE_BIN_CONSTS_SVH
`define TILE_BIN_CONSTS_SVH

// Register byte offsets
`define REG_GLOBAL_CLIP   8'h00
`define REG_ALLOC_CTRL    8'h04
`define REG_LIST_BASE     8'h08
`define REG_INIT_NEXT     8'h0C
`define REG_RUN_NEXT      8'h10
`define REG_LIST_INIT     8'h14
`define REG_LIST_CONT     8'h18
`define REG_LIST_LIMIT    8'h1C
`define REG_RB_INDEX      8'h20
`define REG_RB_DATA       8'h24
`define REG_STATUS        8'h28

// Global clip field positions (tile numbers)
`define GC_XMAX_LSB       0
`define GC_XMIN_LSB       8
`define GC_YMAX_LSB       16
`define GC_YMIN_LSB       24

// Allocation control: one 2-bit size code per list, stride 4
`define ALLOC_STRIDE      4
`define BLK_NONE          2'h0

// Tile grid
`define TILE_COLS         40
`define TILE_ROWS         15
`define TILE_COUNT        600
`define TILE_SHIFT        5
`define LIST_COUNT        5
`define MAX_STRIP         6
`define PB_DEPTH          3000

// Object list word formats
`define LINK_TAG          4'hE
`define EOL_TAG           4'hF

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3

`endif

// File: src/tile_bin_pkg.sv
package tile_bin_pkg;

  typedef enum logic [1:0] {
    PK_VTX   = 2'h0,
    PK_POLY  = 2'h1,
    PK_UCLIP = 2'h2,
    PK_EOL   = 2'h3
  } param_kind_t;

  typedef enum logic [1:0] {
    UC_OFF     = 2'h0,
    UC_INSIDE  = 2'h1,
    UC_OUTSIDE = 2'h2
  } uclip_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SCAN  = 3'h1,
    ST_RDW   = 3'h3,
    ST_WRITE = 3'h2,
    ST_CLEAR = 3'h4
  } bin_state_t;

  typedef struct packed {
    param_kind_t kind;
    logic [2:0]  list;
    logic [2:0]  strip_len;
    logic        end_of_strip;
    uclip_mode_t uclip_mode;
    logic [5:0]  ux_min;
    logic [3:0]  uy_min;
    logic [5:0]  ux_max;
    logic [3:0]  uy_max;
    logic [31:0] x;
    logic [31:0] y;
    logic [23:0] param_addr;
  } param_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [31:0] data;
  } mem_wr_t;

  typedef struct packed {
    logic        used;
    logic        dead;
    logic [4:0]  pos;
    logic [23:0] addr;
  } ptr_entry_t;

endpackage

// File: src/tile_ptr_ram.sv
`timescale 1ns/100ps
module tile_ptr_ram #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 3000,
  parameter int AW    = 12
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data registered, one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// File: src/tile_binning_list_builder.sv
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "tile_bin_consts.svh"
module tile_binning_list_builder
  import tile_bin_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        param_valid,
  output logic             param_ready,
  input  wire param_t      param,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output mem_wr_t          mem_wr
);
  // Register bus
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic [31:0] gclip_r, alloc_r, base_r, init_next_r, limit_r;
  logic [11:0] rb_idx_r;
  logic [23:0] run_next_r;

  // Binning engine
  bin_state_t  state_r;
  logic [11:0] idx_r;
  logic [5:0]  tx_r, bx0_r, bx1_r, sx0_r, sx1_r, px_r;
  logic [3:0]  ty_r, by0_r, by1_r, sy0_r, sy1_r, py_r;
  logic [2:0]  list_r, len_r, tri_r;
  logic [1:0]  vcnt_r;
  uclip_mode_t umode_r;
  logic [5:0]  ux0_r, ux1_r;
  logic [3:0]  uy0_r, uy1_r;
  logic        eol_mode_r, pend_r;
  logic [31:0] obj_r;
  mem_wr_t     pend_wr_r;

  wire do_write = aw_hold_r && w_hold_r && !bvalid;
  wire wr_hit   = (aw_addr_r <= `REG_STATUS) && (aw_addr_r[1:0] == 2'h0);
  wire cmd_init = do_write && (aw_addr_r == `REG_LIST_INIT);
  wire cmd_cont = do_write && (aw_addr_r == `REG_LIST_CONT);
  wire [31:0] strb_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                           {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready   <= 1'b0;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gclip_r     <= 32'h0000_0000;
      alloc_r     <= 32'h0000_0000;
      base_r      <= 32'h0000_0000;
      init_next_r <= 32'h0000_0000;
      limit_r     <= 32'h0000_0000;
      rb_idx_r    <= 12'h000;
    end else if (do_write) begin
      unique case (aw_addr_r)
        `REG_GLOBAL_CLIP: gclip_r <= merge(gclip_r, w_data_r, strb_mask);
        `REG_ALLOC_CTRL:  alloc_r <= merge(alloc_r, w_data_r, strb_mask);
        `REG_LIST_BASE:   base_r  <= merge(base_r, w_data_r, strb_mask);
        `REG_INIT_NEXT:
          init_next_r <= merge(init_next_r, w_data_r, strb_mask);
        `REG_LIST_LIMIT:  limit_r <= merge(limit_r, w_data_r, strb_mask);
        `REG_RB_INDEX:    rb_idx_r <= w_data_r[11:0];
        default: ;
      endcase
    end
  end

  // Geometry from the global clip and block sizes
  wire [5:0] gx0 = gclip_r[`GC_XMIN_LSB +: 6];
  wire [5:0] gx1 = gclip_r[`GC_XMAX_LSB +: 6];
  wire [3:0] gy0 = gclip_r[`GC_YMIN_LSB +: 4];
  wire [3:0] gy1 = gclip_r[`GC_YMAX_LSB +: 4];
  wire [5:0] gw  = 6'(gx1 - gx0 + 6'd1);
  wire [9:0] gc_tiles = 10'(gw * 10'(gy1 - gy0 + 4'd1));
  wire [9:0] tnum = 10'(10'(ty_r - gy0) * 10'(gw) + 10'(tx_r - gx0));

  function automatic logic [5:0] blk_words(input logic [1:0] code);
    blk_words = (code == `BLK_NONE) ? 6'd0 : 6'(6'd4 << code);
  endfunction

  logic [7:0] prefix;
  always_comb begin
    prefix = 8'd0;
    for (int i = 0; i < `LIST_COUNT; i++) begin
      if (3'(i) < list_r) begin
        prefix = prefix + 8'(blk_words(alloc_r[i*`ALLOC_STRIDE +: 2]));
      end
    end
  end

  wire [5:0]  sz_w = blk_words(alloc_r[list_r*`ALLOC_STRIDE +: 2]);
  wire [5:0]  pz_w = blk_words(alloc_r[param.list*`ALLOC_STRIDE +: 2]);
  wire [23:0] sz_b = {16'h0, sz_w, 2'b00};
  wire [18:0] off_w = 19'(19'(prefix) * 19'(gc_tiles))
                    + 19'(19'(sz_w) * 19'(tnum));
  wire [23:0] init_a = base_r[23:0] + {3'h0, off_w, 2'b00};

  // Coordinate to tile number: truncate, then divide by tile size
  function automatic logic [5:0] to_tile(input logic [31:0] f,
                                         input logic [5:0]  lim);
    logic [7:0]  e;
    logic [23:0] iv;
    e = f[30:23];
    if (f[31] || e < 8'd127) begin
      iv = 24'h000000;
    end else if (e > 8'd137) begin
      iv = 24'hFFFFFF;
    end else begin
      iv = {1'b1, f[22:0]} >> (8'd150 - e);
    end
    if (iv[23:`TILE_SHIFT] > {13'h0, lim}) begin
      to_tile = lim;
    end else begin
      to_tile = iv[`TILE_SHIFT +: 6];
    end
  endfunction

  wire [5:0] vx = to_tile(param.x, 6'(`TILE_COLS - 1));
  wire [5:0] vtmp = to_tile(param.y, 6'(`TILE_ROWS - 1));
  wire [3:0] vy = vtmp[3:0];

  // Strip segmenting
  wire       is_vol  = (param.list == 3'd1) || (param.list == 3'd3);
  wire [2:0] eff_len = is_vol ? 3'd1
                     : (len_r == 3'd0) ? 3'd1
                     : (len_r > 3'(`MAX_STRIP)) ? 3'(`MAX_STRIP) : len_r;
  wire [2:0] tri_n = tri_r + 3'd1;
  wire       is_tri = vcnt_r == 2'd2;
  wire       emit = is_tri && ((tri_n == eff_len) || param.end_of_strip);
  wire [5:0] nx0 = (vx < sx0_r) ? vx : sx0_r;
  wire [5:0] nx1 = (vx > sx1_r) ? vx : sx1_r;
  wire [3:0] ny0 = (vy < sy0_r) ? vy : sy0_r;
  wire [3:0] ny1 = (vy > sy1_r) ? vy : sy1_r;
  wire [5:0] cx0 = (nx0 > gx0) ? nx0 : gx0;
  wire [5:0] cx1 = (nx1 < gx1) ? nx1 : gx1;
  wire [3:0] cy0 = (ny0 > gy0) ? ny0 : gy0;
  wire [3:0] cy1 = (ny1 < gy1) ? ny1 : gy1;
  wire       box_ok = (cx0 <= cx1) && (cy0 <= cy1);
  wire       take = (state_r == ST_IDLE) && param_valid && param_ready;

  // Tile walk
  wire       scan_end = (tx_r == bx1_r) && (ty_r == by1_r);
  wire [5:0] nx_tx = (tx_r == bx1_r) ? bx0_r : 6'(tx_r + 6'd1);
  wire [3:0] nx_ty = (tx_r == bx1_r) ? 4'(ty_r + 4'd1) : ty_r;
  wire       in_u = (tx_r >= ux0_r) && (tx_r <= ux1_r)
                 && (ty_r >= uy0_r) && (ty_r <= uy1_r);
  wire       tile_ok = eol_mode_r || (umode_r == UC_OFF)
                    || ((umode_r == UC_INSIDE) && in_u)
                    || ((umode_r == UC_OUTSIDE) && !in_u);
  wire [11:0] tile_idx = 12'(12'(list_r) * 12'(`TILE_COUNT)
                       + 12'(ty_r) * 12'(`TILE_COLS) + 12'(tx_r));

  // Pointer buffer
  ptr_entry_t ent, ent_nxt;
  logic [30:0] pb_rdata;
  wire         pb_we = (state_r == ST_CLEAR)
                    || ((state_r == ST_RDW) && !eol_mode_r);
  wire [11:0]  pb_waddr = (state_r == ST_CLEAR) ? idx_r : tile_idx;
  wire [30:0]  pb_wdata = (state_r == ST_CLEAR) ? 31'h0 : ent_nxt;
  wire [11:0]  pb_raddr = (state_r == ST_IDLE) ? rb_idx_r : tile_idx;
  assign ent = ptr_entry_t'(pb_rdata);

  tile_ptr_ram #(
    .WIDTH (31),
    .DEPTH (`PB_DEPTH),
    .AW    (12)
  ) u_ptr_ram (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (pb_we),
    .waddr   (pb_waddr),
    .wdata   (pb_wdata),
    .raddr   (pb_raddr),
    .rdata   (pb_rdata)
  );

  // Decision for one tile, from its buffer entry
  wire [23:0] cur_a = ent.used ? ent.addr : init_a;
  wire [4:0]  cur_p = ent.used ? ent.pos : 5'd0;
  wire        blk_last = {1'b0, cur_p} == 6'(sz_w - 6'd1);
  wire [24:0] new_end = {1'b0, run_next_r} + {1'b0, sz_b} - 25'd1;
  wire        over = new_end > {1'b0, limit_r[23:0]};
  wire [31:0] eol_w = {`EOL_TAG, 28'h0};
  logic       skip, grow, two;
  mem_wr_t    w1, w2;

  always_comb begin
    ent_nxt = ent;
    skip = 1'b0;
    grow = 1'b0;
    two = 1'b0;
    w1 = '{addr: cur_a, data: obj_r};
    w2 = '{addr: run_next_r, data: obj_r};
    if (eol_mode_r) begin
      skip = ent.dead;
      w1.data = eol_w;
    end else if (ent.dead) begin
      skip = 1'b1;
    end else if (blk_last && over) begin
      w1.data = {`LINK_TAG, 4'h0, limit_r[23:0]};
      w2 = '{addr: limit_r[23:0], data: eol_w};
      two = 1'b1;
      ent_nxt.dead = 1'b1;
    end else if (blk_last) begin
      w1.data = {`LINK_TAG, 4'h0, run_next_r};
      two = 1'b1;
      grow = 1'b1;
      ent_nxt = '{used: 1'b1, dead: 1'b0, pos: 5'd1,
                  addr: run_next_r + 24'd4};
    end else if (cur_a > limit_r[23:0]) begin
      w1 = '{addr: limit_r[23:0], data: eol_w};
      ent_nxt.dead = 1'b1;
    end else begin
      ent_nxt = '{used: 1'b1, dead: 1'b0, pos: 5'(cur_p + 5'd1),
                  addr: cur_a + 24'd4};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      param_ready <= 1'b1;
      mem_valid <= 1'b0;
      mem_wr <= '0;
      pend_r <= 1'b0;
      pend_wr_r <= '0;
      run_next_r <= 24'h000000;
      idx_r <= 12'h000;
      {tx_r, ty_r, bx0_r, bx1_r, by0_r, by1_r} <= '0;
      {sx0_r, sx1_r, sy0_r, sy1_r, px_r, py_r} <= '0;
      {list_r, len_r, tri_r, vcnt_r, eol_mode_r} <= '0;
      {ux0_r, ux1_r, uy0_r, uy1_r} <= '0;
      umode_r <= UC_OFF;
      obj_r <= 32'h0000_0000;
    end else if (cmd_init || cmd_cont) begin
      state_r <= ST_CLEAR;
      idx_r <= 12'h000;
      param_ready <= 1'b0;
      mem_valid <= 1'b0;
      pend_r <= 1'b0;
      vcnt_r <= 2'd0;
      tri_r <= 3'd0;
      if (cmd_init) begin
        run_next_r <= init_next_r[23:0];
      end
    end else begin
      unique case (state_r)
        ST_CLEAR: begin
          idx_r <= 12'(idx_r + 12'd1);
          if (idx_r == 12'(`PB_DEPTH - 1)) begin
            state_r <= ST_IDLE;
            param_ready <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (take) begin
            unique case (param.kind)
              PK_POLY: begin
                list_r <= param.list;
                len_r <= param.strip_len;
                umode_r <= param.uclip_mode;
                vcnt_r <= 2'd0;
                tri_r <= 3'd0;
              end
              PK_UCLIP: begin
                {ux0_r, uy0_r} <= {param.ux_min, param.uy_min};
                {ux1_r, uy1_r} <= {param.ux_max, param.uy_max};
              end
              PK_EOL: begin
                vcnt_r <= 2'd0;
                if (sz_w != 6'd0) begin
                  eol_mode_r <= 1'b1;
                  {tx_r, bx0_r, bx1_r} <= {gx0, gx0, gx1};
                  {ty_r, by0_r, by1_r} <= {gy0, gy0, gy1};
                  state_r <= ST_SCAN;
                  param_ready <= 1'b0;
                end
              end
              default: begin
                if (pz_w != 6'd0) begin
                  {px_r, py_r} <= {vx, vy};
                  if (!is_tri) begin
                    vcnt_r <= 2'(vcnt_r + 2'd1);
                    {sx0_r, sx1_r} <= (vcnt_r == 2'd0) ? {vx, vx} : {nx0, nx1};
                    {sy0_r, sy1_r} <= (vcnt_r == 2'd0) ? {vy, vy} : {ny0, ny1};
                  end else if (!emit) begin
                    tri_r <= tri_n;
                    {sx0_r, sx1_r, sy0_r, sy1_r} <= {nx0, nx1, ny0, ny1};
                  end else begin
                    tri_r <= 3'd0;
                    vcnt_r <= (param.end_of_strip || is_vol) ? 2'd0 : 2'd2;
                    sx0_r <= (vx < px_r) ? vx : px_r;
                    sx1_r <= (vx > px_r) ? vx : px_r;
                    sy0_r <= (vy < py_r) ? vy : py_r;
                    sy1_r <= (vy > py_r) ? vy : py_r;
                    obj_r <= {1'b0, tri_n, 4'h0, param.param_addr};
                    eol_mode_r <= 1'b0;
                    {tx_r, bx0_r, bx1_r} <= {cx0, cx0, cx1};
                    {ty_r, by0_r, by1_r} <= {cy0, cy0, cy1};
                    if (box_ok) begin
                      state_r <= ST_SCAN;
                      param_ready <= 1'b0;
                    end
                  end
                end
              end
            endcase
          end
        end
        ST_SCAN: begin
          if (tile_ok) begin
            state_r <= ST_RDW;
          end else begin
            {tx_r, ty_r} <= {nx_tx, nx_ty};
            state_r <= scan_end ? ST_IDLE : ST_SCAN;
            param_ready <= scan_end;
          end
        end
        ST_RDW: begin
          if (skip) begin
            {tx_r, ty_r} <= {nx_tx, nx_ty};
            state_r <= scan_end ? ST_IDLE : ST_SCAN;
            param_ready <= scan_end;
          end else begin
            state_r <= ST_WRITE;
            mem_valid <= 1'b1;
            mem_wr <= w1;
            pend_r <= two;
            pend_wr_r <= w2;
            if (grow) begin
              run_next_r <= run_next_r + sz_b;
            end
          end
        end
        ST_WRITE: begin
          if (mem_ready) begin
            if (pend_r) begin
              mem_wr <= pend_wr_r;
              pend_r <= 1'b0;
            end else begin
              mem_valid <= 1'b0;
              {tx_r, ty_r} <= {nx_tx, nx_ty};
              state_r <= scan_end ? ST_IDLE : ST_SCAN;
              param_ready <= scan_end;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Read side; readback data is only current while the engine is idle
  logic [31:0] rd_mux;
  wire         rd_hit = (araddr <= `REG_STATUS) && (araddr[1:0] == 2'h0);
  always_comb begin
    unique case (araddr)
      `REG_GLOBAL_CLIP: rd_mux = gclip_r;
      `REG_ALLOC_CTRL:  rd_mux = alloc_r;
      `REG_LIST_BASE:   rd_mux = base_r;
      `REG_INIT_NEXT:   rd_mux = init_next_r;
      `REG_RUN_NEXT:    rd_mux = {8'h00, run_next_r};
      `REG_LIST_LIMIT:  rd_mux = limit_r;
      `REG_RB_INDEX:    rd_mux = {20'h0, rb_idx_r};
      `REG_RB_DATA:     rd_mux = {1'b0, pb_rdata};
      `REG_STATUS:      rd_mux = {29'h0, state_r};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// File: testbench/tile_bin_checker_assertions.sv
`timescale 1ns/100ps
`include "tile_bin_consts.svh"
module tile_bin_checker
  import tile_bin_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        param_ready,
  input wire logic        mem_valid,
  input wire logic        mem_ready,
  input wire mem_wr_t     mem_wr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_bad; arvalid && arready && araddr > `REG_STATUS; endsequence
  // Address and data land in holding registers first, so one idle cycle
  property p_b_after_wr; s_wr_taken |=> !bvalid ##1 bvalid; endproperty
  a_b_after_wr: assert property (p_b_after_wr)
    else $error("write response late");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_aw_block; bvalid |-> !awready && !wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken early");
  property p_r_bad; s_rd_bad |=> rresp == `RESP_DECERR && rdata == '0;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("unmapped read answered");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_mem_hold;
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory write dropped");
  property p_eol_word;
    mem_valid && mem_wr.data[31:28] == `EOL_TAG |-> mem_wr.data[27:0] == '0;
  endproperty
  a_eol_word: assert property (p_eol_word)
    else $error("bad terminator");
  property p_idle_quiet; param_ready |-> !mem_valid; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("write while idle");
endmodule

// File: testbench/tex_mem_model.sv
`timescale 1ns/100ps
module tex_mem_model
  import tile_bin_pkg::*;
(
  input  wire logic    aclk,
  input  wire logic    mem_valid,
  output logic         mem_ready,
  input  wire mem_wr_t mem_wr
);
  logic [31:0] mem [int];
  int          nwr  = 0;
  logic        slow = 1'b0;
  // Stall every other cycle so both held and prompt takes occur
  always @(posedge aclk) begin
    slow <= !slow;
    if (mem_valid && mem_ready) begin
      mem[int'(mem_wr.addr)] = mem_wr.data;
      nwr++;
    end
  end
  assign mem_ready = slow;
endmodule

// File: testbench/tile_binning_list_builder_tb_top.sv
`timescale 1ns/100ps
`include "tile_bin_consts.svh"
module tile_binning_list_builder_tb_top;
  import tile_bin_pkg::*;
  logic        aclk = 0, aresetn = 0, param_valid = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        mem_valid, mem_ready, param_ready;
  logic [1:0]  bresp, rresp, wr_resp;
  param_t      param = '0, pp = '0;
  mem_wr_t     mem_wr;
  int          num_errors = 0, checks = 0;
  localparam logic [31:0] EOL = 32'hF0000000;
  always #50 aclk = !aclk;
  tile_binning_list_builder u_tile_binning_list_builder (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .param_valid(param_valid),
    .param_ready(param_ready), .param(param), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_wr(mem_wr));
  tex_mem_model u_tex_mem_model (.aclk(aclk), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_wr(mem_wr));
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    $display("wrong value at %0t: handshake timeout", $time);
    give_verdict;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; wstrb <= 4'hF;
    bready <= 1;
    repeat (50) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        wr_resp = bresp;
        bready <= 0;
        return;
      end
    end
    hang;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1; araddr <= a; rready <= 1;
    repeat (50) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata; r = rresp; rready <= 0;
        return;
      end
    end
    hang;
  endtask
  task automatic send(input param_kind_t k, input logic [31:0] x, y,
                      input logic e);
    @(posedge aclk);
    pp.kind = k; pp.x = x; pp.y = y; pp.end_of_strip = e;
    param_valid <= 1; param <= pp;
    repeat (100) begin
      @(posedge aclk);
      if (param_ready) begin
        param_valid <= 0;
        return;
      end
    end
    hang;
  endtask
  task automatic wait_idle;
    repeat (2) @(posedge aclk);
    repeat (5000) begin
      @(posedge aclk);
      if (param_ready === 1'b1) return;
    end
    hang;
  endtask
  // One triangle: origin, (x,0), (0,y); last vertex closes the strip
  task automatic tri_eol(input logic [31:0] x, y);
    send(PK_POLY, 0, 0, 0);
    send(PK_VTX, 0, 0, 0);
    send(PK_VTX, x, 0, 0);
    send(PK_VTX, 0, y, 1);
    send(PK_EOL, 0, 0, 0);
    wait_idle;
  endtask
  task automatic test_init;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h2C, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `RESP_DECERR});
    axi_wr(8'h2C, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, `RESP_DECERR});
    axi_wr(`REG_GLOBAL_CLIP, 32'h00010001);
    axi_wr(`REG_ALLOC_CTRL, 32'h1);
    axi_wr(`REG_LIST_BASE, 32'h1000);
    axi_wr(`REG_INIT_NEXT, 32'h1080);
    axi_wr(`REG_LIST_LIMIT, 32'hFFFFFC);
    axi_wr(`REG_LIST_INIT, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, `RESP_OKAY});
    axi_rd(`REG_RUN_NEXT, d, r);
    chk(d, 32'h1080);
    wait_idle;
  endtask
  // x to 100.0 passes the clip edge; y 31.9 stays in row 0 if truncated
  task automatic test_tiles;
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    n0 = u_tex_mem_model.nwr;
    pp.strip_len = 3'h1; pp.param_addr = 24'h111;
    tri_eol(32'h42C80000, 32'h41FF3333);
    chk(u_tex_mem_model.nwr - n0, 6);
    chk(u_tex_mem_model.mem[32'h1000] & 32'h8FFFFFFF, 32'h111);
    chk(u_tex_mem_model.mem[32'h1020] & 32'h8FFFFFFF, 32'h111);
    chk(u_tex_mem_model.mem[32'h1004], EOL);
    chk(u_tex_mem_model.mem[32'h1040], EOL);
    // Tile (1,0) of list 0: used, one object, next word 0x1024
    axi_wr(`REG_RB_INDEX, 32'h1);
    axi_rd(`REG_RB_DATA, d, r);
    chk(d, 32'h41001024);
  endtask
  // Eight triangles in one tile overflow its 8-word block
  task automatic test_grow;
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    n0 = u_tex_mem_model.nwr;
    pp.param_addr = 24'h333;
    pp.uclip_mode = UC_OFF;
    send(PK_POLY, 0, 0, 0);
    repeat (10) send(PK_VTX, 0, 0, 0);
    wait_idle;
    chk(u_tex_mem_model.nwr - n0, 9);
    chk(u_tex_mem_model.mem[32'h101C], 32'hE0001080);
    chk(u_tex_mem_model.mem[32'h1080] & 32'h8FFFFFFF, 32'h333);
    axi_rd(`REG_RUN_NEXT, d, r);
    chk(d, 32'h10A0);
  endtask
  task automatic test_cont;
    logic [31:0] d;
    logic [1:0]  r;
    int          n0;
    axi_wr(`REG_INIT_NEXT, 32'h2000);
    axi_wr(`REG_LIST_CONT, 32'h1);
    axi_rd(`REG_RUN_NEXT, d, r);
    chk(d, 32'h1080);
    wait_idle;
    n0 = u_tex_mem_model.nwr;
    pp.param_addr = 24'h222; pp.uclip_mode = UC_OUTSIDE;
    send(PK_UCLIP, 0, 0, 0);
    tri_eol(32'h42200000, 32'h41200000);
    chk(u_tex_mem_model.nwr - n0, 5);
    chk(u_tex_mem_model.mem[32'h1000], EOL);
    chk(u_tex_mem_model.mem[32'h1020] & 32'h8FFFFFFF, 32'h222);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    test_init;
    test_tiles;
    test_cont;
    test_grow;
    give_verdict;
  end
endmodule
bind tile_binning_list_builder tile_bin_checker u_tile_bin_checker (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .param_ready(param_ready), .mem_valid(mem_valid), .mem_ready(mem_ready),
  .mem_wr(mem_wr));
